// >>> tmrb_pkg.sv
package tmrb_pkg;

  // Pointer values of the register map
  localparam logic [7:0] PTR_LOCAL_HIGH = 8'h00;
  localparam logic [7:0] PTR_REMOTE1_HIGH = 8'h01;
  localparam logic [7:0] PTR_REMOTE2_HIGH = 8'h02;
  localparam logic [7:0] PTR_REMOTE3_HIGH = 8'h03;
  localparam logic [7:0] PTR_CONVERTER_STATE = 8'h08;
  localparam logic [7:0] PTR_RANGE_SHUTDOWN = 8'h09;
  localparam logic [7:0] PTR_CHANNEL_ENABLE = 8'h0a;
  localparam logic [7:0] PTR_SAMPLE_RATE = 8'h0b;
  localparam logic [7:0] PTR_SINGLE_CONV = 8'h0f;
  localparam logic [7:0] PTR_LOCAL_LOW = 8'h10;
  localparam logic [7:0] PTR_REMOTE1_LOW = 8'h11;
  localparam logic [7:0] PTR_REMOTE2_LOW = 8'h12;
  localparam logic [7:0] PTR_REMOTE3_LOW = 8'h13;
  localparam logic [7:0] PTR_IDEALITY_1 = 8'h21;
  localparam logic [7:0] PTR_IDEALITY_2 = 8'h22;
  localparam logic [7:0] PTR_IDEALITY_3 = 8'h23;
  localparam logic [7:0] PTR_SOFT_RESET = 8'hfc;
  localparam logic [7:0] PTR_MAKER_ID = 8'hfe;
  localparam logic [7:0] PTR_PART_ID = 8'hff;

  // Reset values
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_RANGE_SHUTDOWN = 8'h00;
  localparam logic [7:0] RST_CHANNEL_ENABLE = 8'h7c;
  localparam logic [7:0] RST_SAMPLE_RATE = 8'h07;
  localparam logic [7:0] RST_IDEALITY = 8'h00;

  // Identification codes, values arbitrary
  localparam logic [7:0] MAKER_ID_VALUE = 8'h3a;
  localparam logic [7:0] PART_ID_VALUE = 8'h0c;

  // Field positions
  localparam int BIT_BUSY = 7;
  localparam int BIT_SHUTDOWN = 6;
  localparam int BIT_RANGE = 2;
  localparam int BIT_REMOTE3_EN = 6;
  localparam int BIT_REMOTE2_EN = 5;
  localparam int BIT_REMOTE1_EN = 4;
  localparam int BIT_LOCAL_EN = 3;
  localparam int BIT_SERIES_FIX = 2;
  localparam int BIT_VALID = 1;
  localparam int BIT_OPEN = 0;

  // Writable bit masks, reserved bits stay zero
  localparam logic [7:0] MASK_RANGE_SHUTDOWN = 8'h44;
  localparam logic [7:0] MASK_CHANNEL_ENABLE = 8'h7c;
  localparam logic [7:0] MASK_SAMPLE_RATE = 8'h07;

  // Offset added in extended range
  localparam logic [7:0] EXT_RANGE_OFFSET = 8'h40;
  localparam int NUM_CHAN = 4;

  // One finished conversion from the converter
  typedef struct packed {
    logic [1:0] chan;
    logic [7:0] whole;
    logic [3:0] fraction;
    logic open_fault;
  } tmrb_result_t;

  // One byte transaction from the serial framing
  typedef struct packed {
    logic wr;
    logic rd;
    logic ptr_only;
    logic [7:0] data;
  } tmrb_access_t;

endpackage

// >>> tmrb_bank.sv
`timescale 1ns/1ps
// Overview of operation
// - Eight-bit pointer selects register for each access
// - First written data byte loads the pointer
// - Pointer is zero after power-on reset
// - Local high at 00h, low at 10h
// - Remote1 at 01h/11h, remote2 at 02h/12h
// - Remote3 at 03h high, 13h low
// - High byte holds MSBs, low byte LSBs
// - Results read-only, refreshed by each conversion
// - Low read uses shadow from high read
// - Shadow lapses when another register is read
// - Two-byte read from 00h-03h is coherent
// - Two-byte read sends high then low
// - Results read zero after reset
// - Standard format: eight-bit two's complement whole degrees
// - Write to 0Fh starts one-shot, value ignored
// - Write to FCh performs software reset
// - Remote low: fraction, zeros, valid, open
// - Local low: fraction, valid, zeros elsewhere
// - Extended range adds 64 from next conversion
// - Busy flag follows converter activity
// - Shutdown waits for sequence end, clear resumes
// - Sequence local, remotes in order, skip disabled
module tmrb_bank (
  input wire logic clk_sys,
  input wire logic srst,
  input wire tmrb_pkg::tmrb_access_t bus_acc,
  input wire logic conv_done,
  input wire tmrb_pkg::tmrb_result_t conv_result,
  input wire logic conv_busy,
  input wire logic seq_end,
  output logic [7:0] rd_data,
  output logic one_shot_start,
  output logic conv_run,
  output logic [3:0] chan_enable,
  output logic series_fix_enable,
  output logic [2:0] rate_select_bits,
  output logic extended_range,
  output logic [7:0] ideality_adjust_1,
  output logic [7:0] ideality_adjust_2,
  output logic [7:0] ideality_adjust_3
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic [7:0] pointer;
  logic soft_rst;
  logic rst_any;
  logic wr_reg;
  logic rd_reg;
  logic [7:0] result_high [tmrb_pkg::NUM_CHAN];
  logic [7:0] result_low [tmrb_pkg::NUM_CHAN];
  logic [7:0] shadow_low;
  logic shadow_valid;
  logic [1:0] shadow_chan;
  logic [7:0] range_shutdown;
  logic [7:0] channel_enable;
  logic [7:0] sample_rate;
  logic [7:0] ideality [3];
  logic [7:0] next_rd_data;
  logic [7:0] low_sel;

  // Soft reset is a write of any byte to FCh
  assign soft_rst = bus_acc.wr && !bus_acc.ptr_only &&
                    pointer == tmrb_pkg::PTR_SOFT_RESET;
  assign rst_any = srst || soft_rst;
  assign wr_reg = bus_acc.wr && !bus_acc.ptr_only;
  assign rd_reg = bus_acc.rd;

  ////////////////////////////////////////////////////////////////////////
  // Pointer

  // Pointer byte replaces the selection; the first data byte carries it
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      pointer <= tmrb_pkg::RST_POINTER;
    end else if (bus_acc.wr && bus_acc.ptr_only) begin
      pointer <= bus_acc.data;
    end else if (rd_reg && pointer[7:2] == 6'h00) begin
      // Auto-advance high to low for the two-byte read
      pointer <= pointer | tmrb_pkg::PTR_LOCAL_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result registers, written only by the converter

  generate
    for (genvar c = 0; c < tmrb_pkg::NUM_CHAN; c++) begin : g_chan
      // Host writes reach here only as the FCh soft reset, so read-only holds by construction
      always_ff @(posedge clk_sys) begin
        if (rst_any) begin
          result_high[c] <= tmrb_pkg::RST_RESULT;
          result_low[c] <= tmrb_pkg::RST_RESULT;
        end else if (conv_done && conv_result.chan == 2'(c)) begin
          // Range flag sampled here so a change acts next conversion
          result_high[c] <= range_shutdown[tmrb_pkg::BIT_RANGE] ?
            conv_result.whole + tmrb_pkg::EXT_RANGE_OFFSET :
            conv_result.whole;
          result_low[c] <= {conv_result.fraction, 2'b00, 1'b1,
            (c == 0) ? 1'b0 : conv_result.open_fault};
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Low-byte shadow

  // Copy taken at the high read; any other read drops it
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      shadow_low <= tmrb_pkg::RST_RESULT;
      shadow_valid <= 1'b0;
      shadow_chan <= 2'b00;
    end else if (rd_reg) begin
      if (pointer[7:2] == 6'h00) begin
        shadow_low <= result_low[pointer[1:0]];
        shadow_chan <= pointer[1:0];
        shadow_valid <= 1'b1;
      end else begin
        shadow_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  // Writes to read-only pointers fall through and store nothing
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      range_shutdown <= tmrb_pkg::RST_RANGE_SHUTDOWN;
      channel_enable <= tmrb_pkg::RST_CHANNEL_ENABLE;
      sample_rate <= tmrb_pkg::RST_SAMPLE_RATE;
      ideality[0] <= tmrb_pkg::RST_IDEALITY;
      ideality[1] <= tmrb_pkg::RST_IDEALITY;
      ideality[2] <= tmrb_pkg::RST_IDEALITY;
    end else if (wr_reg) begin
      unique case (pointer)
        tmrb_pkg::PTR_RANGE_SHUTDOWN: begin
          range_shutdown <= bus_acc.data & tmrb_pkg::MASK_RANGE_SHUTDOWN;
        end
        tmrb_pkg::PTR_CHANNEL_ENABLE: begin
          channel_enable <= bus_acc.data & tmrb_pkg::MASK_CHANNEL_ENABLE;
        end
        tmrb_pkg::PTR_SAMPLE_RATE: begin
          sample_rate <= bus_acc.data & tmrb_pkg::MASK_SAMPLE_RATE;
        end
        tmrb_pkg::PTR_IDEALITY_1: begin
          ideality[0] <= bus_acc.data;
        end
        tmrb_pkg::PTR_IDEALITY_2: begin
          ideality[1] <= bus_acc.data;
        end
        tmrb_pkg::PTR_IDEALITY_3: begin
          ideality[2] <= bus_acc.data;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter control

  // Shutdown takes effect only once the running sequence ends
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      conv_run <= 1'b1;
    end else if (!range_shutdown[tmrb_pkg::BIT_SHUTDOWN]) begin
      conv_run <= 1'b1;
    end else if (conv_run && (seq_end || !conv_busy)) begin
      conv_run <= 1'b0;
    end
  end

  // One-shot pulse; data byte is discarded
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      one_shot_start <= 1'b0;
    end else begin
      one_shot_start <= wr_reg &&
        pointer == tmrb_pkg::PTR_SINGLE_CONV;
    end
  end

  // Enables steer the converter, which skips disabled channels
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chan_enable <= 4'h0;
      series_fix_enable <= 1'b0;
      rate_select_bits <= 3'h0;
      extended_range <= 1'b0;
      ideality_adjust_1 <= 8'h00;
      ideality_adjust_2 <= 8'h00;
      ideality_adjust_3 <= 8'h00;
    end else begin
      chan_enable <= {channel_enable[tmrb_pkg::BIT_REMOTE3_EN],
                      channel_enable[tmrb_pkg::BIT_REMOTE2_EN],
                      channel_enable[tmrb_pkg::BIT_REMOTE1_EN],
                      channel_enable[tmrb_pkg::BIT_LOCAL_EN]};
      series_fix_enable <= channel_enable[tmrb_pkg::BIT_SERIES_FIX];
      rate_select_bits <= sample_rate[2:0];
      extended_range <= range_shutdown[tmrb_pkg::BIT_RANGE];
      ideality_adjust_1 <= ideality[0];
      ideality_adjust_2 <= ideality[1];
      ideality_adjust_3 <= ideality[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  // Low reads use the shadow only for the matching channel
  always_comb begin
    if (shadow_valid && shadow_chan == pointer[1:0]) begin
      low_sel = shadow_low;
    end else begin
      low_sel = result_low[pointer[1:0]];
    end
  end

  always_comb begin
    next_rd_data = 8'h00;
    unique case (pointer)
      tmrb_pkg::PTR_LOCAL_HIGH, tmrb_pkg::PTR_REMOTE1_HIGH,
      tmrb_pkg::PTR_REMOTE2_HIGH, tmrb_pkg::PTR_REMOTE3_HIGH: begin
        next_rd_data = result_high[pointer[1:0]];
      end
      tmrb_pkg::PTR_LOCAL_LOW, tmrb_pkg::PTR_REMOTE1_LOW,
      tmrb_pkg::PTR_REMOTE2_LOW, tmrb_pkg::PTR_REMOTE3_LOW: begin
        next_rd_data = low_sel;
      end
      tmrb_pkg::PTR_CONVERTER_STATE: begin
        next_rd_data = {conv_busy, 7'h00};
      end
      tmrb_pkg::PTR_RANGE_SHUTDOWN: begin
        next_rd_data = range_shutdown;
      end
      tmrb_pkg::PTR_CHANNEL_ENABLE: begin
        next_rd_data = channel_enable;
      end
      tmrb_pkg::PTR_SAMPLE_RATE: begin
        next_rd_data = sample_rate;
      end
      tmrb_pkg::PTR_IDEALITY_1: begin
        next_rd_data = ideality[0];
      end
      tmrb_pkg::PTR_IDEALITY_2: begin
        next_rd_data = ideality[1];
      end
      tmrb_pkg::PTR_IDEALITY_3: begin
        next_rd_data = ideality[2];
      end
      tmrb_pkg::PTR_MAKER_ID: begin
        next_rd_data = tmrb_pkg::MAKER_ID_VALUE;
      end
      tmrb_pkg::PTR_PART_ID: begin
        next_rd_data = tmrb_pkg::PART_ID_VALUE;
      end
      default: begin
        next_rd_data = 8'h00;
      end
    endcase
  end

  // Registered byte presented continuously for the framer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data <= tmrb_pkg::RST_RESULT;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_ptr_load;
    @(posedge clk_sys) disable iff (srst)
      bus_acc.wr && bus_acc.ptr_only |=> pointer == $past(bus_acc.data);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded");

  property p_soft_reset;
    @(posedge clk_sys) disable iff (srst)
      soft_rst |=> pointer == 8'h00 && sample_rate == 8'h07 &&
        channel_enable == 8'h7c;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset incomplete");

  property p_one_shot;
    @(posedge clk_sys) disable iff (srst)
      wr_reg && pointer == 8'h0f |=> one_shot_start;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot missing");

  property p_busy;
    @(posedge clk_sys) disable iff (srst)
      pointer == 8'h08 && !rst_any |=> rd_data[7] == $past(conv_busy);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy flag wrong");

  property p_shadow_lapse;
    @(posedge clk_sys) disable iff (srst)
      rd_reg && pointer[7:2] != 6'h00 && !soft_rst |=> !shadow_valid;
  endproperty
  a_shadow_lapse: assert property (p_shadow_lapse)
    else $error("shadow kept");

  property p_two_byte;
    @(posedge clk_sys) disable iff (srst)
      rd_reg && pointer[7:2] == 6'h00 && !bus_acc.wr |=>
        pointer == ($past(pointer) | 8'h10);
  endproperty
  a_two_byte: assert property (p_two_byte)
    else $error("no advance to low");

  property p_ro_write;
    @(posedge clk_sys) disable iff (srst)
      wr_reg && pointer == 8'h08 |=> $stable(range_shutdown) &&
        $stable(sample_rate);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write stored");

  property p_local_low;
    @(posedge clk_sys) disable iff (srst)
      conv_done && conv_result.chan == 2'd0 && !rst_any |=>
        result_low[0][3:0] == 4'h2;
  endproperty
  a_local_low: assert property (p_local_low)
    else $error("local low layout");

endmodule

// >>> tmrb_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host controller seen through the framer: one-cycle byte pulses
module tmrb_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] rd_data,
  output tmrb_pkg::tmrb_access_t bus_acc
);
  // Idle bus before the first transaction
  initial begin
    bus_acc = '0;
  end

  // Raise for one edge, then idle with inverted data so stale bytes never pass
  task automatic pulse(input logic w, input logic r, input logic p,
                       input logic [7:0] d);
    @(negedge clk_sys);
    bus_acc = '{wr: w, rd: r, ptr_only: p, data: d};
    @(negedge clk_sys);
    bus_acc = '{wr: 1'b0, rd: 1'b0, ptr_only: 1'b0, data: ~d};
    @(negedge clk_sys);
  endtask

  // First data byte of every write is the pointer
  task automatic set_ptr(input logic [7:0] p);
    pulse(1'b1, 1'b0, 1'b1, p);
  endtask

  // Data byte to the selected register
  task automatic wr_data(input logic [7:0] d);
    pulse(1'b1, 1'b0, 1'b0, d);
  endtask

  // Full write transaction
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    set_ptr(p);
    wr_data(d);
  endtask

  // Byte is taken before rd is pulsed, then the pointer may advance
  task automatic read_byte(output logic [7:0] d);
    d = rd_data;
    pulse(1'b0, 1'b1, 1'b0, bus_acc.data);
  endtask

  // Pointer is always set before a read
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    set_ptr(p);
    read_byte(d);
  endtask
endmodule

// >>> temp_monitor_register_bank_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
////////////////////////////////////////////////////////////////////////////////
module temp_monitor_register_bank_tb;
  typedef struct packed {
    logic [1:0] ch; logic [7:0] whole; logic [3:0] frac; logic opn;
    logic [7:0] hi; logic [7:0] lo;
  } tmrb_row_t;
  typedef struct packed {
    logic [7:0] ptr; logic [7:0] wd; logic [7:0] ex;
  } tmrb_reg_t;
  logic clk_sys, srst, conv_done, conv_busy, seq_end;
  tmrb_pkg::tmrb_access_t bus_acc;
  tmrb_pkg::tmrb_result_t conv_result;
  logic [7:0] rd_data, ideality_adjust_1, ideality_adjust_2;
  logic [7:0] ideality_adjust_3, v;
  logic one_shot_start, conv_run, series_fix_enable, extended_range;
  logic [3:0] chan_enable;
  logic [2:0] rate_select_bits;
  int n_errors = 0;
  int compares = 0;
  int os_cnt = 0;
  // Conversions per channel with the bytes they must read back as
  tmrb_row_t rows [5] = '{'{2'd0, 8'h19, 4'h4, 1'b0, 8'h19, 8'h42},
    '{2'd1, 8'hec, 4'h8, 1'b1, 8'hec, 8'h83},
    '{2'd2, 8'h7f, 4'hf, 1'b0, 8'h7f, 8'hf2},
    '{2'd3, 8'hc0, 4'h1, 1'b1, 8'hc0, 8'h13},
    '{2'd0, 8'h00, 4'h0, 1'b1, 8'h00, 8'h02}};
  // Power-on contents of the readable control and identity registers
  tmrb_reg_t por_tab [9] = '{'{8'h08, 8'h00, 8'h00},
    '{8'h09, 8'h00, 8'h00}, '{8'h0a, 8'h00, 8'h7c}, '{8'h0b, 8'h00, 8'h07},
    '{8'h21, 8'h00, 8'h00}, '{8'h22, 8'h00, 8'h00}, '{8'h23, 8'h00, 8'h00},
    '{8'hfe, 8'h00, tmrb_pkg::MAKER_ID_VALUE},
    '{8'hff, 8'h00, tmrb_pkg::PART_ID_VALUE}};
  // Writes with the value each must read back as, reserved bits cleared
  tmrb_reg_t wr_tab [6] = '{'{8'h09, 8'hff, 8'h44},
    '{8'h0a, 8'h08, 8'h08}, '{8'h0b, 8'hff, 8'h07}, '{8'h21, 8'ha5, 8'ha5},
    '{8'h22, 8'h5a, 8'h5a}, '{8'h23, 8'h3c, 8'h3c}};

  tmrb_host_model host (
    .clk_sys(clk_sys),
    .rd_data(rd_data),
    .bus_acc(bus_acc)
  );

  tmrb_bank dut (
    .clk_sys(clk_sys),
    .srst(srst),
    .bus_acc(bus_acc),
    .conv_done(conv_done),
    .conv_result(conv_result),
    .conv_busy(conv_busy),
    .seq_end(seq_end),
    .rd_data(rd_data),
    .one_shot_start(one_shot_start),
    .conv_run(conv_run),
    .chan_enable(chan_enable),
    .series_fix_enable(series_fix_enable),
    .rate_select_bits(rate_select_bits),
    .extended_range(extended_range),
    .ideality_adjust_1(ideality_adjust_1),
    .ideality_adjust_2(ideality_adjust_2),
    .ideality_adjust_3(ideality_adjust_3)
  );

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Counts one-shot cycles; a stretched pulse shows up as a count above one
  always @(posedge clk_sys) begin
    if (one_shot_start === 1'b1) os_cnt++;
  end

  // One finished conversion; result lines scramble once the pulse is gone
  task automatic post(input logic [1:0] c, input logic [7:0] w,
                      input logic [3:0] f, input logic o);
    @(negedge clk_sys);
    conv_result = '{chan: c, whole: w, fraction: f, open_fault: o};
    conv_done = 1'b1;
    @(negedge clk_sys);
    conv_done = 1'b0;
    conv_result = ~conv_result;
  endtask

  // Reads the whole power-on table back
  task automatic check_por();
    foreach (por_tab[i]) begin
      host.read_reg(por_tab[i].ptr, v);
      `CHK("por reg", por_tab[i].ex, v)
    end
  endtask

  // Single place where the run ends
  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end

  initial begin
    srst = 1'b1;
    conv_done = 1'b0;
    conv_busy = 1'b0;
    seq_end = 1'b0;
    conv_result = '0;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    // Read with no pointer write lands on the local high byte
    host.read_byte(v);
    `CHK("ptr0 read", 8'h00, v)
    host.read_byte(v);
    `CHK("ptr0 low", 8'h00, v)
    check_por();
    `CHK("chan_enable", 4'hf, chan_enable)
    `CHK("conv_run", 1'b1, conv_run)
    `CHK("series fix por", 1'b1, series_fix_enable)
    `CHK("rate por", 3'h7, rate_select_bits)
    $display("test reset done");
    // High then low via auto-advance, then low addressed directly
    foreach (rows[i]) begin
      post(rows[i].ch, rows[i].whole, rows[i].frac, rows[i].opn);
      host.read_reg({6'h00, rows[i].ch}, v);
      `CHK("high", rows[i].hi, v)
      host.read_byte(v);
      `CHK("low", rows[i].lo, v)
      host.read_reg({6'h04, rows[i].ch}, v);
      `CHK("low direct", rows[i].lo, v)
    end
    $display("test rows done");
    // Writes to read-only places leave them untouched
    host.wr_reg(8'h01, 8'h55);
    host.wr_reg(8'hfe, 8'h00);
    host.wr_reg(8'h08, 8'hff);
    host.read_reg(8'h09, v);
    `CHK("ro status", 8'h00, v)
    host.read_reg(8'h01, v);
    `CHK("ro result", 8'hec, v)
    host.read_reg(8'hfe, v);
    `CHK("ro ident", tmrb_pkg::MAKER_ID_VALUE, v)
    // New conversion between high and low read must not leak through
    host.read_reg(8'h02, v);
    `CHK("shadow high", 8'h7f, v)
    post(2'd2, 8'h11, 4'h6, 1'b0);
    host.read_byte(v);
    `CHK("shadow low", 8'hf2, v)
    host.read_reg(8'h08, v);
    host.read_reg(8'h12, v);
    `CHK("lapsed low", 8'h62, v)
    $display("test coherence done");
    // Controls set while busy; shutdown must wait for the sequence end
    conv_busy = 1'b1;
    foreach (wr_tab[i]) begin
      host.wr_reg(wr_tab[i].ptr, wr_tab[i].wd);
      host.read_reg(wr_tab[i].ptr, v);
      `CHK("rw reg", wr_tab[i].ex, v)
    end
    host.read_reg(8'h08, v);
    `CHK("busy", 8'h80, v)
    `CHK("run while busy", 1'b1, conv_run)
    `CHK("ext range", 1'b1, extended_range)
    `CHK("chan_enable", 4'h1, chan_enable)
    `CHK("series fix", 1'b0, series_fix_enable)
    `CHK("rate", 3'h7, rate_select_bits)
    `CHK("adj1", 8'ha5, ideality_adjust_1)
    `CHK("adj2", 8'h5a, ideality_adjust_2)
    `CHK("adj3", 8'h3c, ideality_adjust_3)
    @(negedge clk_sys);
    seq_end = 1'b1;
    @(negedge clk_sys);
    seq_end = 1'b0;
    conv_busy = 1'b0;
    @(negedge clk_sys);
    `CHK("shut down", 1'b0, conv_run)
    post(2'd0, 8'h14, 4'h0, 1'b0);
    host.read_reg(8'h00, v);
    `CHK("ext high", 8'h54, v)
    host.wr_reg(8'h09, 8'h00);
    `CHK("resume", 1'b1, conv_run)
    $display("test control done");
    // Any value to the trigger gives exactly one start pulse
    `CHK("no start yet", 0, os_cnt)
    host.wr_reg(8'h0f, 8'h5a);
    `CHK("one shot", 1, os_cnt)
    // Soft reset puts every writable register back
    host.wr_reg(8'h0b, 8'h03);
    `CHK("rate", 3'h3, rate_select_bits)
    host.wr_reg(8'hfc, 8'h00);
    repeat (2) @(negedge clk_sys);
    check_por();
    `CHK("chan_enable", 4'hf, chan_enable)
    `CHK("ext off", 1'b0, extended_range)
    `CHK("adj off", 8'h00, ideality_adjust_1)
    $display("test soft reset done");
    // Power-on reset mid-run clears pointer and results again
    post(2'd1, 8'h33, 4'h5, 1'b0);
    host.set_ptr(8'h0b);
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    host.read_byte(v);
    `CHK("reset ptr", 8'h00, v)
    host.read_reg(8'h01, v);
    `CHK("reset result", 8'h00, v)
    $display("test mid reset done");
    complete_run();
  end
endmodule
